// ===== shared/motion_ctl_pkg.sv
package motion_ctl_pkg;

  // opcodes handled by this block
  localparam logic [7:0] OP_USER_FIRST = 8'h40;
  localparam logic [7:0] OP_USER_LAST = 8'h47;
  localparam logic [7:0] OP_STOP_APP = 8'h80;
  localparam logic [7:0] OP_RUN_APP = 8'h81;
  localparam logic [7:0] OP_STEP_APP = 8'h82;
  localparam logic [7:0] OP_RESET_APP = 8'h83;
  localparam logic [7:0] OP_DL_ENTER = 8'h84;
  localparam logic [7:0] OP_DL_EXIT = 8'h85;
  localparam logic [7:0] OP_READ_MEM = 8'h86;
  localparam logic [7:0] OP_APP_STATUS = 8'h87;
  localparam logic [7:0] OP_FW_VERSION = 8'h88;
  localparam logic [7:0] OP_RESTORE = 8'h89;
  localparam logic [7:0] OP_POS_REQ = 8'h8A;
  localparam logic [7:0] OP_SW_RESET = 8'hFF;
  localparam logic [7:0] OP_MOVE_DEFAULT = 8'h04;

  // reply fields and unlock key
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_REACHED = 8'h80;
  localparam logic [7:0] HOST_ADDR = 8'h02;
  localparam logic [31:0] UNLOCK_KEY = 32'h0000_04D2;

  // register byte offsets
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_VALUE = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_EVENTS = 8'h0C;
  localparam logic [7:0] ADDR_REPLY_STAT = 8'h10;
  localparam logic [7:0] ADDR_REPLY_VALUE = 8'h14;
  localparam logic [7:0] ADDR_REPLY_AUX = 8'h18;
  localparam logic [7:0] ADDR_DEFER = 8'h1C;
  localparam logic [7:0] ADDR_STATE = 8'h20;
  localparam logic [7:0] ADDR_PC = 8'h24;
  localparam logic [7:0] ADDR_ACC = 8'h28;
  localparam logic [7:0] ADDR_XREG = 8'h2C;
  localparam logic [7:0] ADDR_MEMPTR = 8'h30;
  localparam logic [7:0] ADDR_FLAGS = 8'h34;

  // field positions
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_SRC_BIT = 1;
  localparam int EV_REPLY_BIT = 0;
  localparam int EV_DEFER_BIT = 1;

  // widths and reset values
  localparam int PC_W = 16;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [1:0] {ARM_NONE, ARM_ONCE, ARM_EVERY} arm_t;

endpackage

// ===== core/sync_two.sv
`timescale 1ns/1ns
module sync_two (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic din,
  output logic dout
);
  logic stage1_q;

  // two flops against metastability
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1_q <= din;
      dout <= stage1_q;
    end
  end
endmodule // sync_two

// ===== core/prog_mem.sv
`timescale 1ns/1ns
module prog_mem #(
  parameter int W = 56,
  parameter int AW = 8
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  // write port
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read port, one cycle latency
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule // prog_mem

// ===== core/motion_command_control_ops.sv
// Summary of operation
// - opcodes 64..71 are user extensions, replying status 100 with a user value.
// - opcode 138 gives an immediate reply and a later one on target reached.
// - the position reached request is honoured only from the host, never from a program.
// - type 0 arms the next move only, type 1 arms every later move.
// - immediate reply: host 02h, status 64h, command 8Ah, mask in lowest byte.
// - deferred reply has the same layout with status 80h.
// - control opcodes are honoured only from the host, never inside a program.
// - 128 halts the program, 130 runs one instruction then stops.
// - 129 runs; type 0 from current address, type 1 from value address.
// - 131 stops and zeroes program counter, stack, accumulator, index and flags.
// - 132 enters download at value address; later commands are stored, not run.
// - 133 leaves download so commands execute again.
// - 134 returns the program word at the value address.
// - 135 reports mode/wait/pointer, mode/wait/pc, accumulator or index by type.
// - 136 returns version, string form for type 0, binary for type 1.
// - 137 with key 1234 restores factory settings and sends no reply.
// - 255 with key 1234 restarts the processor; reply may not arrive.
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
module motion_command_control_ops
  import motion_ctl_pkg::*;
#(
  parameter logic [7:0] MOVE_OPCODE = OP_MOVE_DEFAULT,
  parameter int MEM_AW = 8,
  parameter logic [31:0] FW_VERSION_STR = 32'h3130_3030, // arbitrary value
  parameter logic [31:0] FW_VERSION_BIN = 32'h0001_0000 // arbitrary value
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  input wire logic targetReached,
  input wire logic engWe,
  input wire logic [PC_W-1:0] engPc,
  input wire logic [31:0] engAcc,
  input wire logic [31:0] engX,
  input wire logic [7:0] engFlags,
  input wire logic [7:0] engSp,
  input wire logic engWait,
  input wire logic [31:0] userReplyValue,
  output logic appRun,
  output logic appStep,
  output logic factoryRestore,
  output logic cpuResetReq
);
  localparam int MEM_W = 56;

  logic [31:0] cmdWord_q, value_q;
  logic goPulse_q, srcProg_q;
  logic running_q, download_q, wait_q;
  logic [PC_W-1:0] pc_q;
  logic [31:0] acc_q, x_q;
  logic [7:0] flags_q, sp_q;
  logic [MEM_AW-1:0] memPtr_q;
  arm_t arm_q;
  logic [7:0] mask_q;
  logic pending_q, deferValid_q;
  logic replyValid_q;
  logic [7:0] rpSt_q, rpCmd_q;
  logic [31:0] rpVal_q, rpAux_q;
  logic memRdPend_q;
  logic reachSync, reachPrev_q;
  logic [MEM_W-1:0] memRdata;
  logic [31:0] readMux;

  // merge write data into a word under byte enables
  function automatic logic [31:0] mergeSel(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // control opcodes of the direct-mode set
  function automatic logic isCtrl(input logic [7:0] op);
    return ((op >= OP_STOP_APP) && (op <= OP_RESTORE)) || (op == OP_SW_RESET);
  endfunction

  // bus decode: one wait state, ack for one cycle
  logic acc;
  logic wr;
  assign acc = wbCyc & wbStb & ~wbAck;
  assign wr = acc & wbWe;

  // decoded fields of the current command
  logic [7:0] op, typ;
  logic exec, direct, directOnly, ctrlOk, keyOk, posReq, dlStore, normal, moveCmd;
  logic reachRise;
  assign op = cmdWord_q[7:0];
  assign typ = cmdWord_q[15:8];
  assign exec = goPulse_q;
  assign direct = ~srcProg_q;
  assign directOnly = isCtrl(op) | (op == OP_POS_REQ);
  assign ctrlOk = exec & direct & isCtrl(op);
  assign keyOk = (value_q == UNLOCK_KEY);
  assign posReq = exec & direct & (op == OP_POS_REQ);
  assign dlStore = exec & download_q & ~directOnly;
  assign normal = exec & ~download_q & ~directOnly;
  assign moveCmd = normal & (op == MOVE_OPCODE);
  assign reachRise = reachSync & ~reachPrev_q;

  sync_two u_reach_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .din(targetReached),
    .dout(reachSync)
  );

  prog_mem #(.W(MEM_W), .AW(MEM_AW)) u_prog_mem (
    .mclk(mclk),
    .arst_n(arst_n),
    .we(dlStore),
    .waddr(memPtr_q),
    .wdata({op, typ, cmdWord_q[23:16], value_q}),
    .raddr(value_q[MEM_AW-1:0]),
    .rdata(memRdata)
  );

  // bus acknowledge and command registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wbAck <= 1'b0;
      cmdWord_q <= RST_WORD;
      value_q <= RST_WORD;
      goPulse_q <= 1'b0;
      srcProg_q <= 1'b0;
    end else begin
      wbAck <= acc;
      goPulse_q <= wr && (wbAdr == ADDR_CTRL) && wbSel[0] && wbDatI[CTRL_GO_BIT];
      if (wr && wbAdr == ADDR_CMD) cmdWord_q <= mergeSel(cmdWord_q, wbDatI, wbSel);
      if (wr && wbAdr == ADDR_VALUE) value_q <= mergeSel(value_q, wbDatI, wbSel);
      if (wr && wbAdr == ADDR_CTRL && wbSel[0]) srcProg_q <= wbDatI[CTRL_SRC_BIT];
    end
  end

  // reply content for the command being executed
  logic ldReply;
  logic [7:0] nSt, nCmd;
  logic [31:0] nVal, nAux;
  always_comb begin
    ldReply = 1'b0;
    nSt = ST_OK;
    nCmd = op;
    nVal = RST_WORD;
    nAux = RST_WORD;
    if (memRdPend_q) begin
      ldReply = 1'b1;
      nCmd = OP_READ_MEM;
      nVal = memRdata[31:0];
      nAux = {8'h00, memRdata[55:32]};
    end else if (dlStore) begin
      ldReply = 1'b1;
    end else if (exec && !(directOnly && !direct)) begin
      case (op)
        OP_POS_REQ: begin
          ldReply = 1'b1;
          nVal = {24'h000000, value_q[7:0]};
        end
        OP_READ_MEM: ldReply = 1'b0;
        OP_APP_STATUS: begin
          ldReply = 1'b1;
          case (typ)
            8'h00: nVal = {6'h00, download_q, running_q, 7'h00, wait_q, 16'(memPtr_q)};
            8'h01: nVal = {6'h00, download_q, running_q, 7'h00, wait_q, pc_q};
            8'h02: nVal = acc_q;
            8'h03: nVal = x_q;
            default: nVal = RST_WORD;
          endcase
        end
        OP_FW_VERSION: begin
          ldReply = 1'b1;
          nVal = (typ == 8'h00) ? FW_VERSION_STR : FW_VERSION_BIN;
        end
        OP_RESTORE: ldReply = 1'b0;
        OP_SW_RESET: ldReply = keyOk;
        default: begin
          ldReply = 1'b1;
          if (op >= OP_USER_FIRST && op <= OP_USER_LAST) nVal = userReplyValue;
        end
      endcase
    end
  end

  // immediate reply registers; a new reply wins over a clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      replyValid_q <= 1'b0;
      rpSt_q <= RST_BYTE;
      rpCmd_q <= RST_BYTE;
      rpVal_q <= RST_WORD;
      rpAux_q <= RST_WORD;
      memRdPend_q <= 1'b0;
    end else begin
      memRdPend_q <= exec && direct && op == OP_READ_MEM && !memRdPend_q;
      if (ldReply) begin
        replyValid_q <= 1'b1;
        rpSt_q <= nSt;
        rpCmd_q <= nCmd;
        rpVal_q <= nVal;
        rpAux_q <= nAux;
      end else if (wr && wbAdr == ADDR_EVENTS && wbSel[0] && wbDatI[EV_REPLY_BIT]) begin
        replyValid_q <= 1'b0;
      end
    end
  end

  // program execution state and engine snapshot
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      running_q <= 1'b0;
      pc_q <= RST_PC;
      acc_q <= RST_WORD;
      x_q <= RST_WORD;
      flags_q <= RST_BYTE;
      sp_q <= RST_BYTE;
      wait_q <= 1'b0;
    end else if (ctrlOk && (op == OP_RESET_APP || (op == OP_SW_RESET && keyOk))) begin
      running_q <= 1'b0;
      pc_q <= RST_PC;
      acc_q <= RST_WORD;
      x_q <= RST_WORD;
      flags_q <= RST_BYTE;
      sp_q <= RST_BYTE;
      wait_q <= 1'b0;
    end else if (ctrlOk && (op == OP_STOP_APP || op == OP_STEP_APP)) begin
      running_q <= 1'b0;
    end else if (ctrlOk && op == OP_RUN_APP) begin
      running_q <= 1'b1;
      if (typ == 8'h01) pc_q <= value_q[PC_W-1:0];
    end else if (engWe) begin
      pc_q <= engPc;
      acc_q <= engAcc;
      x_q <= engX;
      flags_q <= engFlags;
      sp_q <= engSp;
      wait_q <= engWait;
    end
  end

  // download mode and its write pointer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      download_q <= 1'b0;
      memPtr_q <= '0;
    end else if (ctrlOk && op == OP_DL_ENTER) begin
      download_q <= 1'b1;
      memPtr_q <= value_q[MEM_AW-1:0];
    end else if (ctrlOk && (op == OP_DL_EXIT || (op == OP_SW_RESET && keyOk))) begin
      download_q <= 1'b0;
    end else if (dlStore) begin
      memPtr_q <= memPtr_q + MEM_AW'(1);
    end
  end

  // position reached arming and deferred reply
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      arm_q <= ARM_NONE;
      mask_q <= RST_BYTE;
      pending_q <= 1'b0;
      deferValid_q <= 1'b0;
      reachPrev_q <= 1'b0;
    end else begin
      reachPrev_q <= reachSync;
      if (ctrlOk && op == OP_SW_RESET && keyOk) begin
        arm_q <= ARM_NONE;
      end else if (posReq) begin
        mask_q <= value_q[7:0];
        if (typ == 8'h00) arm_q <= ARM_ONCE;
        else if (typ == 8'h01) arm_q <= ARM_EVERY;
      end else if (moveCmd && arm_q == ARM_ONCE) begin
        arm_q <= ARM_NONE;
      end
      if (moveCmd && arm_q != ARM_NONE) pending_q <= 1'b1;
      else if (reachRise || (ctrlOk && op == OP_SW_RESET && keyOk)) pending_q <= 1'b0;
      if (reachRise && pending_q) deferValid_q <= 1'b1;
      else if (wr && wbAdr == ADDR_EVENTS && wbSel[0] && wbDatI[EV_DEFER_BIT]) begin
        deferValid_q <= 1'b0;
      end
    end
  end

  // run level and pulses to the program engine and the system
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      appRun <= 1'b0;
      appStep <= 1'b0;
      factoryRestore <= 1'b0;
      cpuResetReq <= 1'b0;
    end else begin
      appRun <= running_q;
      appStep <= ctrlOk && op == OP_STEP_APP;
      factoryRestore <= ctrlOk && op == OP_RESTORE && keyOk;
      cpuResetReq <= ctrlOk && op == OP_SW_RESET && keyOk;
    end
  end

  // register read map
  always_comb begin
    case (wbAdr)
      ADDR_CMD: readMux = cmdWord_q;
      ADDR_VALUE: readMux = value_q;
      ADDR_CTRL: readMux = {30'h0, srcProg_q, 1'b0};
      ADDR_EVENTS: readMux = {30'h0, deferValid_q, replyValid_q};
      ADDR_REPLY_STAT: readMux = {HOST_ADDR, 8'h00, rpCmd_q, rpSt_q};
      ADDR_REPLY_VALUE: readMux = rpVal_q;
      ADDR_REPLY_AUX: readMux = rpAux_q;
      ADDR_DEFER: readMux = {HOST_ADDR, OP_POS_REQ, ST_REACHED, mask_q};
      ADDR_STATE: readMux = {26'h0, pending_q, arm_q, wait_q, download_q, running_q};
      ADDR_PC: readMux = {16'h0000, pc_q};
      ADDR_ACC: readMux = acc_q;
      ADDR_XREG: readMux = x_q;
      ADDR_MEMPTR: readMux = 32'(memPtr_q);
      ADDR_FLAGS: readMux = {16'h0000, sp_q, flags_q};
      default: readMux = RST_WORD;
    endcase
  end

  // registered read data
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wbDatO <= RST_WORD;
    end else if (acc && !wbWe) begin
      wbDatO <= readMux;
    end
  end
endmodule // motion_command_control_ops

// ===== verif/motion_ops_chk.sv
`timescale 1ns/1ns
module motion_ops_chk (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic wbAck,
  input wire logic appRun,
  input wire logic appStep,
  input wire logic factoryRestore,
  input wire logic cpuResetReq
);
  logic [3:0] sinceWr_q;
  // cycles since the last taken bus write, saturating
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) sinceWr_q <= 4'hF;
    else if (wbCyc && wbStb && wbWe && !wbAck) sinceWr_q <= 4'h0;
    else if (sinceWr_q != 4'hF) sinceWr_q <= sinceWr_q + 4'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // bus handshake
  ackPulse_a: assert property (wbAck |=> !wbAck)
    else $error("ack held too long");
  ackReply_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("ack missing");
  ackCause_a: assert property ($rose(wbAck) |-> $past(wbCyc && wbStb))
    else $error("ack without request");
  // command outputs
  stepPulse_a: assert property (appStep |=> !appStep)
    else $error("step pulse too long");
  restorePulse_a: assert property (factoryRestore |=> !factoryRestore)
    else $error("restore pulse too long");
  resetPulse_a: assert property (cpuResetReq |=> !cpuResetReq)
    else $error("cpu reset pulse too long");
  stepCause_a: assert property (appStep |-> sinceWr_q <= 4'h8)
    else $error("step without command");
  restoreCause_a: assert property (factoryRestore |-> sinceWr_q <= 4'h8 && !cpuResetReq)
    else $error("restore without command");
  runCause_a: assert property ($changed(appRun) |-> sinceWr_q <= 4'h8)
    else $error("run state changed alone");
  quietStart_a: assert property (!$past(arst_n) |-> !appRun && !appStep && !cpuResetReq)
    else $error("outputs active after reset");
  cover property (appStep);
  cover property (factoryRestore);
  cover property (cpuResetReq);
endmodule // motion_ops_chk

bind motion_command_control_ops motion_ops_chk i_chk (.mclk(mclk), .arst_n(arst_n),
  .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAck(wbAck), .appRun(appRun),
  .appStep(appStep), .factoryRestore(factoryRestore), .cpuResetReq(cpuResetReq));

// ===== verif/motor_side_model.sv
`timescale 1ns/1ns
module motor_side_model
  import motion_ctl_pkg::*;
#(
  parameter int DELAY = 8,
  parameter logic [31:0] ACC_V = 32'h0,
  parameter logic [31:0] X_V = 32'h0
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic moveGo,
  input wire logic snapGo,
  output logic targetReached,
  output logic engWe,
  output logic [PC_W-1:0] engPc,
  output logic [31:0] engAcc,
  output logic [31:0] engX,
  output logic [7:0] engFlags,
  output logic [7:0] engSp,
  output logic engWait
);
  logic [7:0] left_q;
  // fixed engine snapshot
  assign engPc = 16'h0123;
  assign engAcc = ACC_V;
  assign engX = X_V;
  assign engFlags = 8'h5A;
  assign engSp = 8'h03;
  assign engWait = 1'b1;
  // snapshot strobe one cycle after the request
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) engWe <= 1'b0;
    else engWe <= snapGo;
  end
  // leaves target on a move, arrives DELAY cycles after
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      left_q <= 8'h00;
      targetReached <= 1'b0;
    end else if (moveGo) begin
      left_q <= 8'(DELAY);
      targetReached <= 1'b0;
    end else if (left_q == 8'h01) begin
      left_q <= 8'h00;
      targetReached <= 1'b1;
    end else if (left_q != 8'h00) left_q <= left_q - 8'h01;
  end
endmodule // motor_side_model

// ===== verif/motion_command_control_ops_test.sv
`timescale 1ns/1ns
module motion_command_control_ops_test
  import motion_ctl_pkg::*;
;
  localparam logic [31:0] V_STR = 32'h5A5A_0001; // arbitrary value
  localparam logic [31:0] V_BIN = 32'h0002_0003; // arbitrary value
  localparam logic [31:0] USR_V = 32'hCAFE_0042;
  localparam logic [31:0] ACC_V = 32'h1111_2222;
  localparam logic [31:0] X_V = 32'h3333_4444;
  logic mclk, arst_n, wbCyc, wbStb, wbWe, wbAck, moveGo, snapGo, gotRep, expHit;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatI, wbDatO, rs, rv, tmp;
  logic targetReached, engWe, engWait, appRun, appStep, factoryRestore, cpuResetReq;
  logic [PC_W-1:0] engPc;
  logic [31:0] engAcc, engX;
  logic [7:0] engFlags, engSp;
  int miscompares, checksDone, cycles, nStep, nRestore, nCpuRst;

  motion_command_control_ops #(.FW_VERSION_STR(V_STR), .FW_VERSION_BIN(V_BIN)) i_dut (
    .mclk(mclk), .arst_n(arst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
    .targetReached(targetReached), .engWe(engWe), .engPc(engPc), .engAcc(engAcc),
    .engX(engX), .engFlags(engFlags), .engSp(engSp), .engWait(engWait),
    .userReplyValue(USR_V), .appRun(appRun), .appStep(appStep),
    .factoryRestore(factoryRestore), .cpuResetReq(cpuResetReq));

  motor_side_model #(.ACC_V(ACC_V), .X_V(X_V)) i_motor (.mclk(mclk), .arst_n(arst_n),
    .moveGo(moveGo), .snapGo(snapGo), .targetReached(targetReached), .engWe(engWe),
    .engPc(engPc), .engAcc(engAcc), .engX(engX), .engFlags(engFlags), .engSp(engSp),
    .engWait(engWait));

  // clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // pulse counters and timeout
  always @(posedge mclk) begin
    cycles++;
    nStep += int'(appStep === 1'b1);
    nRestore += int'(factoryRestore === 1'b1);
    nCpuRst += int'(cpuResetReq === 1'b1);
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude();
    if (miscompares == 0 && checksDone > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chkWord(input string nm, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkFlag(input string nm, input logic e, input logic g);
    checksDone++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask

  // one classic cycle, held until ack is sampled
  task automatic wbXfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
    @(posedge mclk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatI <= d;
    do @(posedge mclk); while (wbAck !== 1'b1);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    wbXfer(a, 1'b0, 32'h0, tmp);
  endtask

  // issue a command, poll for a reply, fetch and acknowledge it
  task automatic cmd(input logic [7:0] op, input logic [7:0] ty, input logic [31:0] v,
                     input logic prog);
    wbXfer(ADDR_CMD, 1'b1, {16'h0000, ty, op}, tmp);
    wbXfer(ADDR_VALUE, 1'b1, v, tmp);
    wbXfer(ADDR_CTRL, 1'b1, {30'h0, prog, 1'b1}, tmp);
    gotRep = 1'b0;
    repeat (6) begin
      rd(ADDR_EVENTS);
      if (tmp[EV_REPLY_BIT] === 1'b1) gotRep = 1'b1;
    end
    wbXfer(ADDR_REPLY_STAT, 1'b0, 32'h0, rs);
    wbXfer(ADDR_REPLY_VALUE, 1'b0, 32'h0, rv);
    wbXfer(ADDR_EVENTS, 1'b1, 32'h1, tmp);
  endtask

  initial begin
    arst_n = 1'b0;
    {wbCyc, wbStb, wbWe, moveGo, snapGo} = 5'h00;
    wbAdr = 8'h00;
    wbSel = 4'hF;
    wbDatI = 32'h0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      cmd(OP_USER_FIRST + 8'(i), 8'h00, 32'h0, 1'b0);
      chkWord("user stat", {HOST_ADDR, 8'h00, OP_USER_FIRST + 8'(i), ST_OK}, rs);
      chkWord("user value", USR_V, rv);
    end
    for (int t = 1; t >= 0; t--) begin
      cmd(OP_POS_REQ, 8'(t), 32'h1, 1'b0);
      chkWord("pos stat", 32'h0200_8A64, rs);
      chkWord("pos mask", 32'h0000_0001, rv);
      for (int m = 0; m < 2; m++) begin
        expHit = (t == 1 || m == 0);
        cmd(OP_MOVE_DEFAULT, 8'h00, 32'h100, 1'b0);
        moveGo <= 1'b1;
        rd(ADDR_STATE);
        moveGo <= 1'b0;
        chkFlag("move armed", expHit, tmp[5]);
        repeat (10) begin
          rd(ADDR_EVENTS);
          if (tmp[EV_DEFER_BIT] === 1'b1) break;
        end
        chkFlag("deferred", expHit, tmp[EV_DEFER_BIT]);
        rd(ADDR_DEFER);
        if (expHit) chkWord("deferred reply", 32'h028A_8001, tmp);
        wbXfer(ADDR_EVENTS, 1'b1, 32'h2, tmp);
      end
    end
    for (int k = 0; k < 12; k++) begin
      cmd((k == 11) ? OP_SW_RESET : OP_STOP_APP + 8'(k), 8'h01, UNLOCK_KEY, 1'b1);
      chkFlag("program refused", 1'b0, gotRep);
    end
    chkWord("program pulses", 32'h0, nRestore + nCpuRst + nStep);
    rd(ADDR_STATE);
    chkWord("program state", 32'h0, tmp);
    cmd(OP_RUN_APP, 8'h00, 32'h0, 1'b0);
    chkFlag("run", 1'b1, appRun);
    cmd(OP_STOP_APP, 8'h00, 32'h0, 1'b0);
    chkFlag("stop", 1'b0, appRun);
    cmd(OP_RUN_APP, 8'h01, 32'h10, 1'b0);
    chkFlag("run at address", 1'b1, appRun);
    rd(ADDR_PC);
    chkWord("run address", 32'h0000_0010, tmp);
    snapGo <= 1'b1;
    @(posedge mclk);
    snapGo <= 1'b0;
    cmd(OP_APP_STATUS, 8'h02, 32'h0, 1'b0);
    chkWord("acc", ACC_V, rv);
    cmd(OP_APP_STATUS, 8'h03, 32'h0, 1'b0);
    chkWord("xreg", X_V, rv);
    cmd(OP_APP_STATUS, 8'h01, 32'h0, 1'b0);
    chkWord("mode pc", 32'h0101_0123, rv);
    cmd(OP_RESET_APP, 8'h00, 32'h0, 1'b0);
    chkFlag("reset stops", 1'b0, appRun);
    for (int a = 0; a < 4; a++) begin
      rd((a == 3) ? ADDR_FLAGS : ADDR_PC + 8'(4 * a));
      chkWord("cleared", 32'h0, tmp);
    end
    cmd(OP_STEP_APP, 8'h00, 32'h0, 1'b0);
    chkWord("steps", 32'h1, nStep);
    cmd(OP_DL_ENTER, 8'h00, 32'h3, 1'b0);
    cmd(8'h05, 8'h02, 32'h0000_1234, 1'b0);
    rd(ADDR_MEMPTR);
    chkWord("memptr", 32'h4, tmp);
    cmd(OP_APP_STATUS, 8'h00, 32'h0, 1'b0);
    chkWord("mode memptr", 32'h0200_0004, rv);
    cmd(OP_DL_EXIT, 8'h00, 32'h0, 1'b0);
    cmd(8'h05, 8'h02, 32'h0000_1234, 1'b0);
    rd(ADDR_MEMPTR);
    chkWord("memptr after exit", 32'h4, tmp);
    cmd(OP_READ_MEM, 8'h00, 32'h3, 1'b0);
    chkWord("mem value", 32'h0000_1234, rv);
    rd(ADDR_REPLY_AUX);
    chkWord("mem aux", 32'h0005_0200, tmp);
    cmd(OP_FW_VERSION, 8'h00, 32'h0, 1'b0);
    chkWord("version string", V_STR, rv);
    cmd(OP_FW_VERSION, 8'h01, 32'h0, 1'b0);
    chkWord("version binary", V_BIN, rv);
    cmd(OP_RESTORE, 8'h00, UNLOCK_KEY - 32'h1, 1'b0);
    cmd(OP_SW_RESET, 8'h00, UNLOCK_KEY + 32'h1, 1'b0);
    chkWord("wrong key", 32'h0, nRestore + nCpuRst + 32'(gotRep));
    cmd(OP_RESTORE, 8'h00, UNLOCK_KEY, 1'b0);
    chkFlag("restore silent", 1'b0, gotRep);
    chkWord("restores", 32'h1, nRestore);
    cmd(OP_SW_RESET, 8'h00, UNLOCK_KEY, 1'b0);
    chkWord("cpu resets", 32'h1, nCpuRst);
    conclude();
  end
endmodule // motion_command_control_ops_test
